/* deep_sleep_pkg.sv */
// Constants, types and encodings shared by the deep sleep wakeup controller
package deep_sleep_pkg;
   localparam int NUM_EXT = 4;
   localparam int NUM_INT = 8;
   localparam int STACK_DEPTH = 4;
   localparam int SHORT_DELAY_CYC = 256;
   localparam int LONG_DELAY_CYC = 4096;
   localparam logic [12:0] SHORT_LOAD = 13'(SHORT_DELAY_CYC - 1);
   localparam logic [12:0] LONG_LOAD = 13'(LONG_DELAY_CYC - 1);
   localparam logic [7:0] ADDR_EXT_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_MASK = 8'h02;
   localparam logic [7:0] ADDR_STATE = 8'h03;
   localparam int ST_SLEEP_ENTER = 0;
   localparam int ST_WAKE_IRQ = 1;
   localparam int ST_WAKE_RESET = 2;
   localparam int ST_WDG_RESET = 3;
   localparam int ST_ENTRY_REFUSED = 4;
   localparam logic [7:0] EXT_CTRL_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [1:0] CC_PRIO_RST = 2'b11;
   localparam logic [1:0] PRIO_SLEEP = 2'b10;
   localparam logic [1:0] SENSE_FALL_LOW = 2'b00;
   localparam logic [1:0] SENSE_RISE = 2'b01;
   localparam logic [1:0] SENSE_FALL = 2'b10;
   localparam logic [1:0] SENSE_BOTH = 2'b11;

   typedef enum logic [3:0] {
      S_RUN = 4'b0001,
      S_SLEEP = 4'b0010,
      S_LOAD = 4'b0100,
      S_STAB = 4'b1000
   } sleep_state_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic enter;
      logic ret;
      logic load;
      logic [1:0] load_val;
      logic [1:0] int_level;
   } cc_ctrl_s;
endpackage

/* ext_irq_sense.sv */
// One external interrupt source with selectable pin sensitivity
`timescale 1ns/1ps
module ext_irq_sense (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic pin,
   input wire logic [1:0] sense,
   input wire logic clear,
   input wire logic ack,
   output logic pending
);
   import deep_sleep_pkg::*;
   logic pin_q;
   logic set_now;

   always_comb begin
      case (sense)
         SENSE_FALL_LOW: set_now = (pin_q & ~pin) | ~pin;
         SENSE_RISE: set_now = ~pin_q & pin;
         SENSE_FALL: set_now = pin_q & ~pin;
         default: set_now = pin_q ^ pin;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_q <= 1'b1;
      end else begin
         pin_q <= pin;
      end
   end

   // Set wins over a clear or acknowledge in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pending <= 1'b0;
      end else begin
         pending <= set_now | (pending & ~clear & ~ack);
      end
   end

   sense_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      (clear && !set_now) |=> !pending)
      else $error("pending survived a sensitivity change");
   sense_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
      (sense == SENSE_FALL && pin_q && !pin) |=> pending)
      else $error("falling edge not caught");
endmodule

/* deep_sleep_wakeup_ctrl.sv */
// Deep sleep entry, wakeup, oscillator stabilization and interrupt priority control
`timescale 1ns/1ps
module deep_sleep_wakeup_ctrl (
   input wire logic ref_clk,
   input wire logic rst,
   input wire deep_sleep_pkg::reg_req_s bus,
   output logic [7:0] rdata,
   input wire logic sleep_instr,
   input wire logic clock_output_int_enable,
   input wire logic auto_wakeup_enable,
   input wire logic watchdog_sleep_option,
   input wire logic watchdog_enabled,
   input wire logic long_delay_sel,
   input wire logic [deep_sleep_pkg::NUM_INT-1:0] wake_capable_mask,
   input wire logic [deep_sleep_pkg::NUM_INT-1:0] int_src_req,
   input wire logic [deep_sleep_pkg::NUM_EXT-1:0] ext_pin,
   input wire logic [deep_sleep_pkg::NUM_EXT-1:0] ext_ack,
   input wire deep_sleep_pkg::cc_ctrl_s cc_ctrl,
   output logic [1:0] cc_prio,
   output logic [deep_sleep_pkg::NUM_EXT-1:0] ext_pending,
   output logic osc_enable,
   output logic periph_clk_en,
   output logic aux_clk_en,
   output logic cpu_hold,
   output logic service_irq,
   output logic fetch_reset_vector,
   output logic wdg_reset_req,
   output logic irq
);
   import deep_sleep_pkg::*;

   sleep_state_e state;
   sleep_state_e next_state;
   logic [12:0] delay_cnt;
   logic cause_reset;
   logic long_q;
   logic [7:0] ext_irq_ctrl_reg;
   logic [7:0] status;
   logic [7:0] irq_mask;
   logic [7:0] next_status;
   logic [7:0] events;
   logic [NUM_EXT-1:0] sense_clear;
   logic [1:0] prio_stack [0:STACK_DEPTH-1];
   logic [2:0] sp;
   logic gate_ok;
   logic wdg_trip;
   logic enter_sleep;
   logic wake_any;
   logic stab_done;
   logic ctrl_wr;
   logic status_rd;
   logic [7:0] next_mask;

   function automatic logic hit(input reg_req_s r, input logic [7:0] a);
      hit = r.addr == a;
   endfunction

   assign ctrl_wr = bus.wr & hit(bus, ADDR_EXT_CTRL);
   assign status_rd = bus.rd & hit(bus, ADDR_STATUS);
   // Mask writes reach the interrupt line in the same cycle as the register
   assign next_mask = (bus.wr && hit(bus, ADDR_MASK)) ? bus.wdata : irq_mask;
   assign gate_ok = ~clock_output_int_enable & ~auto_wakeup_enable;
   assign wdg_trip = watchdog_enabled & ~watchdog_sleep_option;
   assign enter_sleep = (state == S_RUN) & sleep_instr & gate_ok & ~wdg_trip;
   // External sources always wake; internal ones only where masked in
   assign wake_any = (|(int_src_req & wake_capable_mask)) | (|ext_pending);
   assign stab_done = (state == S_STAB) & (delay_cnt == 13'h0000);

   // Sensitivity pairs, one source each
   genvar g;
   generate
      for (g = 0; g < NUM_EXT; g++) begin : g_ext
         assign sense_clear[g] = ctrl_wr &
            (bus.wdata[2*g +: 2] != ext_irq_ctrl_reg[2*g +: 2]);
         ext_irq_sense u_sense (
            .ref_clk(ref_clk),
            .rst(rst),
            .pin(ext_pin[g]),
            .sense(ext_irq_ctrl_reg[2*g +: 2]),
            .clear(sense_clear[g]),
            .ack(ext_ack[g]),
            .pending(ext_pending[g])
         );
      end
   endgenerate

   always_comb begin
      case (state)
         S_RUN: next_state = enter_sleep ? S_SLEEP : S_RUN;
         S_SLEEP: next_state = wake_any ? S_LOAD : S_SLEEP;
         S_LOAD: next_state = S_STAB;
         S_STAB: next_state = stab_done ? S_RUN : S_STAB;
         default: next_state = S_RUN;
      endcase
   end

   // Reset acts as a wakeup: it passes through the stabilization delay
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= S_LOAD;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cause_reset <= 1'b1;
      end else if (state == S_SLEEP && wake_any) begin
         cause_reset <= 1'b0;
      end else if (stab_done) begin
         cause_reset <= 1'b0;
      end
   end

   // Delay length sampled once, when the counter is loaded
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         delay_cnt <= 13'h0000;
         long_q <= 1'b0;
      end else if (state == S_LOAD) begin
         long_q <= long_delay_sel;
         delay_cnt <= long_delay_sel ? LONG_LOAD : SHORT_LOAD;
      end else if (state == S_STAB && delay_cnt != 13'h0000) begin
         delay_cnt <= delay_cnt - 13'h0001;
      end
   end

   // Oscillator, peripheral clock and CPU hold follow the next state; the aux clock stays enabled
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         osc_enable <= 1'b1;
         periph_clk_en <= 1'b0;
         aux_clk_en <= 1'b1;
         cpu_hold <= 1'b1;
      end else begin
         osc_enable <= next_state != S_SLEEP;
         periph_clk_en <= next_state == S_RUN;
         aux_clk_en <= 1'b1;
         cpu_hold <= next_state != S_RUN;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         service_irq <= 1'b0;
         fetch_reset_vector <= 1'b0;
         wdg_reset_req <= 1'b0;
      end else begin
         service_irq <= stab_done & ~cause_reset;
         fetch_reset_vector <= stab_done & cause_reset;
         wdg_reset_req <= (state == S_RUN) & sleep_instr & gate_ok & wdg_trip;
      end
   end

   // Priority bits with a push/pop stack for nested routines
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cc_prio <= CC_PRIO_RST;
         sp <= 3'h0;
      end else if (enter_sleep) begin
         cc_prio <= PRIO_SLEEP;
      end else if (cc_ctrl.enter) begin
         if (sp < 3'(STACK_DEPTH)) begin
            prio_stack[sp[1:0]] <= cc_prio;
            sp <= sp + 3'h1;
         end
         cc_prio <= cc_ctrl.int_level;
      end else if (cc_ctrl.ret) begin
         if (sp != 3'h0) begin
            cc_prio <= prio_stack[2'(sp - 3'h1)];
            sp <= sp - 3'h1;
         end
      end else if (cc_ctrl.load) begin
         cc_prio <= cc_ctrl.load_val;
      end
   end

   // Software is expected to write this only at priority level 3
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ext_irq_ctrl_reg <= EXT_CTRL_RST;
         irq_mask <= MASK_RST;
      end else if (ctrl_wr) begin
         ext_irq_ctrl_reg <= bus.wdata;
      end else if (bus.wr && hit(bus, ADDR_MASK)) begin
         irq_mask <= bus.wdata;
      end
   end

   always_comb begin
      events = 8'h00;
      events[ST_SLEEP_ENTER] = enter_sleep;
      events[ST_WAKE_IRQ] = stab_done & ~cause_reset;
      events[ST_WAKE_RESET] = stab_done & cause_reset;
      events[ST_WDG_RESET] = (state == S_RUN) & sleep_instr & gate_ok & wdg_trip;
      events[ST_ENTRY_REFUSED] = (state == S_RUN) & sleep_instr & ~gate_ok;
      next_status = (status & ~(status_rd ? 8'hff : 8'h00)) | events;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status <= 8'h00;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         irq <= |(next_status & next_mask);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            ADDR_EXT_CTRL: rdata <= ext_irq_ctrl_reg;
            ADDR_STATUS: rdata <= status;
            ADDR_MASK: rdata <= irq_mask;
            ADDR_STATE: rdata <= {ext_pending, state};
            default: rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // Helper: cycles spent in the stabilization state
   logic [12:0] stab_len;
   always_ff @(posedge ref_clk) begin
      if (rst || state != S_STAB) begin
         stab_len <= 13'h0000;
      end else begin
         stab_len <= stab_len + 13'h0001;
      end
   end

   entry_gated_a: assert property (@(posedge ref_clk) disable iff (rst)
      (state == S_RUN && sleep_instr && !gate_ok) |=> state == S_RUN)
      else $error("sleep entered with an enable set");
   entry_taken_a: assert property (@(posedge ref_clk) disable iff (rst)
      (state == S_RUN && sleep_instr && gate_ok && !wdg_trip) |=> state == S_SLEEP)
      else $error("sleep not entered");
   prio_force_a: assert property (@(posedge ref_clk) disable iff (rst)
      enter_sleep |=> cc_prio == 2'b10)
      else $error("priority not forced on entry");
   wake_start_a: assert property (@(posedge ref_clk) disable iff (rst)
      (state == S_SLEEP && wake_any) |=> state == S_LOAD ##1 state == S_STAB && osc_enable)
      else $error("wakeup sequence wrong");
   osc_off_a: assert property (@(posedge ref_clk) disable iff (rst)
      state == S_SLEEP |-> !osc_enable && !periph_clk_en && aux_clk_en)
      else $error("clocks running in deep sleep");
   delay_len_a: assert property (@(posedge ref_clk) disable iff (rst)
      stab_done |-> stab_len == (long_q ? LONG_LOAD : SHORT_LOAD) && cpu_hold)
      else $error("stabilization delay wrong length");
   resume_kind_a: assert property (@(posedge ref_clk) disable iff (rst)
      stab_done |=> (fetch_reset_vector == $past(cause_reset)) && (service_irq != fetch_reset_vector))
      else $error("wrong resume kind");
   wdg_trip_a: assert property (@(posedge ref_clk) disable iff (rst)
      (state == S_RUN && sleep_instr && gate_ok && wdg_trip) |=> wdg_reset_req && state == S_RUN)
      else $error("watchdog request missing");
   prio_push_a: assert property (@(posedge ref_clk) disable iff (rst)
      (cc_ctrl.enter && !enter_sleep && sp < 3'h4) ##1 (cc_ctrl == '0 && !enter_sleep)
      ##1 (cc_ctrl.ret && !cc_ctrl.enter && !enter_sleep) |=> cc_prio == $past(cc_prio, 3))
      else $error("priority not restored by return");
   irq_level_a: assert property (@(posedge ref_clk) disable iff (rst)
      irq == |(status & irq_mask))
      else $error("interrupt line disagrees with status");
   // Sequencing and register checks
   hold_release_a: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(cpu_hold) |-> service_irq || fetch_reset_vector)
      else $error("cpu released without a resume pulse");
   periph_run_a: assert property (@(posedge ref_clk) disable iff (rst)
      periph_clk_en == (state == S_RUN))
      else $error("peripheral clock outside run state");
   wake_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
      (state == S_SLEEP && (int_src_req & wake_capable_mask) == 8'h00 && ext_pending == 4'h0)
      |=> state == S_SLEEP)
      else $error("woke without a wake-capable source");
   pending_wake_a: assert property (@(posedge ref_clk) disable iff (rst)
      (enter_sleep && ext_pending != 4'h0 && ext_ack == 4'h0 && !ctrl_wr) |-> ##2 state == S_LOAD)
      else $error("pending interrupt did not wake at once");
   sp_bound_a: assert property (@(posedge ref_clk) disable iff (rst)
      sp <= 3'(STACK_DEPTH))
      else $error("priority stack pointer out of range");
   rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
      !bus.rd |=> rdata == 8'h00)
      else $error("read data outside a read");
   load_once_a: assert property (@(posedge ref_clk) disable iff (rst)
      (state == S_STAB && $past(state) == S_STAB) |-> $stable(long_q))
      else $error("delay choice changed while counting");
   status_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
      status_rd |=> status == $past(events))
      else $error("status not cleared by read");
   resume_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
      (service_irq || fetch_reset_vector) |-> state == S_RUN && !cpu_hold)
      else $error("resume pulse while cpu held");

   sleep_c: cover property (@(posedge ref_clk) disable iff (rst) enter_sleep);
   irq_wake_c: cover property (@(posedge ref_clk) disable iff (rst)
      stab_done && !cause_reset);
   long_delay_c: cover property (@(posedge ref_clk) disable iff (rst) stab_done && long_q);
   wdg_c: cover property (@(posedge ref_clk) disable iff (rst) wdg_reset_req);
   pend_entry_c: cover property (@(posedge ref_clk) disable iff (rst)
      enter_sleep && ext_pending != 4'h0);
endmodule

/* cpu_pin_model.sv */
// Far-side model: external interrupt pins and CPU acknowledge of external sources
`timescale 1ns/1ps
module cpu_pin_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [deep_sleep_pkg::NUM_EXT-1:0] pin_lvl,
   input wire logic ack_on,
   input wire logic [1:0] lat,
   input wire logic [deep_sleep_pkg::NUM_EXT-1:0] ext_pending,
   output logic [deep_sleep_pkg::NUM_EXT-1:0] ext_pin,
   output logic [deep_sleep_pkg::NUM_EXT-1:0] ext_ack
);
   import deep_sleep_pkg::*;
   logic [1:0] wait_cnt;
   // Pins follow the commanded level one cycle later
   always_ff @(posedge ref_clk) begin
      ext_pin <= pin_lvl;
   end
   // CPU services pending sources after lat cycles with a single acknowledge pulse
   always_ff @(posedge ref_clk) begin
      if (rst || !ack_on || ext_pending == '0 || ext_ack != '0) begin
         wait_cnt <= 2'd0;
         ext_ack <= '0;
      end else if (wait_cnt >= lat) begin
         ext_ack <= ext_pending;
      end else begin
         wait_cnt <= wait_cnt + 2'd1;
      end
   end
endmodule

/* deep_sleep_wakeup_ctrl_test.sv */
// Self-checking testbench of the deep sleep wakeup controller
`timescale 1ns/1ps
module deep_sleep_wakeup_ctrl_test;
   import deep_sleep_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   reg_req_s bus = '0;
   cc_ctrl_s cc_ctrl = '0;
   logic [7:0] rdata, v;
   logic sleep_instr = 1'b0, clock_output_int_enable = 1'b0, auto_wakeup_enable = 1'b0;
   logic watchdog_sleep_option = 1'b1, watchdog_enabled = 1'b0, long_delay_sel = 1'b0;
   logic [7:0] wake_capable_mask = 8'h00, int_src_req = 8'h00;
   logic [3:0] ext_pin, ext_ack, ext_pending;
   logic [3:0] pin_lvl = 4'hf;
   logic ack_on = 1'b0;
   logic [1:0] lat = 2'd0, lvl, lvl2, cc_prio;
   logic osc_enable, periph_clk_en, aux_clk_en, cpu_hold, service_irq;
   logic fetch_reset_vector, wdg_reset_req, irq;
   int bad_count = 0, tests_run = 0, cycles = 0, src;

   deep_sleep_wakeup_ctrl i_dut (.ref_clk, .rst, .bus, .rdata, .sleep_instr,
      .clock_output_int_enable, .auto_wakeup_enable, .watchdog_sleep_option,
      .watchdog_enabled, .long_delay_sel, .wake_capable_mask, .int_src_req, .ext_pin,
      .ext_ack, .cc_ctrl, .cc_prio, .ext_pending, .osc_enable, .periph_clk_en,
      .aux_clk_en, .cpu_hold, .service_irq, .fetch_reset_vector, .wdg_reset_req, .irq);
   cpu_pin_model i_cpu (.ref_clk, .rst, .pin_lvl, .ack_on, .lat, .ext_pending,
      .ext_pin, .ext_ack);

   always #5 ref_clk = ~ref_clk;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("Checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Inputs change just after the edge so outputs are settled when looked at
   task automatic tick(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      tick(1);
      bus <= '0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      tick(1);
      bus <= '0;
      d = rdata;
      tick(1);
   endtask
   task automatic cpu_cc(input cc_ctrl_s c);
      cc_ctrl <= c;
      tick(1);
      cc_ctrl <= '0;
      tick(1);
   endtask
   task automatic sleep_go;
      sleep_instr <= 1'b1;
      tick(1);
      sleep_instr <= 1'b0;
   endtask
   function automatic int stab_cycles(input logic long_sel, input int extra);
      return (long_sel ? LONG_DELAY_CYC : SHORT_DELAY_CYC) + extra;
   endfunction
   function automatic logic exp_pend(input int m, input logic fell, input logic rose);
      return (fell && m != SENSE_RISE) || (rose && (m == SENSE_RISE || m == SENSE_BOTH));
   endfunction
   task automatic time_wake(input int d, input logic by_irq);
      int k;
      k = 0;
      do begin
         tick(1);
         k++;
      end while ((by_irq ? service_irq : fetch_reset_vector) !== 1'b1 && k < 5000);
      check(k, d);
      check(cpu_hold, 1'b0);
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_sim();
      end
   end

   initial begin
      void'($urandom(32'h6e8235ef));
      tick(10);
      rst <= 1'b0;
      time_wake(stab_cycles(1'b0, 1), 1'b0);
      check(cc_prio, CC_PRIO_RST);
      rd(ADDR_STATUS, v);
      check(v, 8'h04);
      rd(8'h04 + 8'($urandom_range(251)), v);
      check(v, 8'h00);
      wr(ADDR_MASK, 8'h01);
      rd(ADDR_MASK, v);
      check(v, 8'h01);
      for (int e = 1; e < 4; e++) begin
         {auto_wakeup_enable, clock_output_int_enable} <= 2'(e);
         sleep_go();
         check(osc_enable, 1'b1);
         check(irq, 1'b0);
         rd(ADDR_STATUS, v);
         check(v, 8'h10);
      end
      {auto_wakeup_enable, clock_output_int_enable} <= 2'b00;
      watchdog_enabled <= 1'b1;
      watchdog_sleep_option <= 1'b0;
      sleep_go();
      check({wdg_reset_req, osc_enable}, 2'b11);
      watchdog_sleep_option <= 1'b1;
      rd(ADDR_STATUS, v);
      check(v, 8'h08);
      for (int i = 0; i < 3; i++) begin
         src = $urandom_range(7);
         long_delay_sel <= (i == 2);
         wake_capable_mask <= 8'(1 << src);
         sleep_go();
         check(cc_prio, PRIO_SLEEP);
         check({osc_enable, periph_clk_en, aux_clk_en, cpu_hold, irq}, 5'b00111);
         int_src_req <= ~wake_capable_mask;
         tick(5);
         check(osc_enable, 1'b0);
         int_src_req <= 8'hff;
         time_wake(stab_cycles(i == 2, 2), 1'b1);
         int_src_req <= 8'h00;
         rd(ADDR_STATUS, v);
         check(v, 8'h03);
         check(irq, 1'b0);
      end
      lvl = 2'($urandom_range(3));
      lvl2 = ~lvl;
      cpu_cc('{enter: 1'b1, int_level: lvl, default: '0});
      check(cc_prio, lvl);
      cpu_cc('{enter: 1'b1, int_level: lvl2, default: '0});
      check(cc_prio, lvl2);
      cpu_cc('{ret: 1'b1, default: '0});
      check(cc_prio, lvl);
      cpu_cc('{ret: 1'b1, default: '0});
      check(cc_prio, PRIO_SLEEP);
      cpu_cc('{load: 1'b1, load_val: CC_PRIO_RST, default: '0});
      check(cc_prio, CC_PRIO_RST);
      for (int m = 0; m < 4; m++) begin
         src = $urandom_range(3);
         lat <= 2'($urandom_range(3));
         wr(ADDR_EXT_CTRL, 8'(m << (2 * src)));
         pin_lvl[src] <= 1'b0;
         tick(4);
         check(ext_pending, 4'(exp_pend(m, 1'b1, 1'b0) << src));
         pin_lvl[src] <= 1'b1;
         tick(4);
         check(ext_pending, 4'(exp_pend(m, 1'b1, 1'b1) << src));
         ack_on <= 1'b1;
         tick(8);
         ack_on <= 1'b0;
         check(ext_pending, 4'h0);
      end
      wr(ADDR_EXT_CTRL, {4{SENSE_RISE}});
      pin_lvl <= 4'h0;
      tick(4);
      pin_lvl <= 4'hf;
      tick(4);
      wr(ADDR_EXT_CTRL, {4{SENSE_RISE}});
      check(ext_pending, 4'hf);
      wr(ADDR_EXT_CTRL, {{3{SENSE_RISE}}, SENSE_BOTH});
      check(ext_pending, 4'he);
      rd(ADDR_EXT_CTRL, v);
      check(v, 8'h57);
      rd(ADDR_STATE, v);
      check(v, 8'he1);
      wake_capable_mask <= 8'h00;
      long_delay_sel <= 1'b0;
      sleep_go();
      check(osc_enable, 1'b0);
      time_wake(stab_cycles(1'b0, 2), 1'b1);
      ack_on <= 1'b1;
      tick(8);
      ack_on <= 1'b0;
      sleep_go();
      tick(3);
      check(osc_enable, 1'b0);
      rst <= 1'b1;
      tick(2);
      rst <= 1'b0;
      time_wake(stab_cycles(1'b0, 1), 1'b0);
      check(cc_prio, CC_PRIO_RST);
      end_sim();
   end
endmodule
